// *** dv/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// master side of the line; only ever pulls low, the pull-up gives the high level
module host_model #(
	parameter int ACK_C  = 16,
	parameter int LOW_C  = 10,
	parameter int ZERO_C = 5,
	parameter int ONE_C  = 14,
	parameter int STOP_C = 9
) (
	input  wire logic clk_i,
	input  wire logic oe_i,
	output logic      pull_o
);
	initial pull_o = 1'b0;
	task automatic span(input logic lvl, output int t);
		t = 0;
		while (oe_i === lvl && t < 500) begin
			t++;
			@(posedge clk_i);
		end
	endtask
	// bad counts widths off their typical value, and a stop only when shorter than STOP_C; -1 means no answer came
	task automatic xfer(input int n, output logic [39:0] f, output int bad, output logic ok);
		int t;
		int k;
		bad = 0;
		k = 0;
		pull_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		pull_o <= 1'b0;
		while (oe_i !== 1'b1 && k < 100) begin
			k++;
			@(posedge clk_i);
		end
		if (k >= 100) begin
			bad = -1;
			return;
		end
		span(1'b1, t);
		bad += int'(t != ACK_C);
		span(1'b0, t);
		bad += int'(t != ACK_C);
		for (int i = 39; i >= 0; i--) begin
			span(1'b1, t);
			bad += int'(t != LOW_C);
			span(1'b0, t);
			f[i] = (t == ONE_C);
			bad += int'(t != ONE_C && t != ZERO_C);
		end
		span(1'b1, t);
		bad += int'(t < STOP_C);
		ok = (f[39:32] + f[31:24] + f[23:16] + f[15:8]) == f[7:0];
	endtask
endmodule
`default_nettype wire

// *** dv/one_wire_sensor_readout_link_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module one_wire_sensor_readout_link_tb;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        pull;
	logic        oe;
	logic        busy;
	logic [15:0] hum = 16'h0;
	logic        neg = 1'b0;
	logic [14:0] mag = 15'h0;
	int          n_mismatch = 0;
	int          n_tests = 0;
	logic        drv;
	logic        taken;
	int          n_taken = 0;
	int          n_bad_pull = 0;
	// typical phase lengths scaled down by a common divider so a reading takes about a thousand cycles
	localparam int DIV    = 5;
	localparam int WAKE_C = onewire_pkg::WAKE_MIN_US / DIV;
	localparam int ACK_C  = onewire_pkg::ACK_LOW_US / DIV;
	localparam int LOW_C  = onewire_pkg::BIT_LOW_US / DIV;
	localparam int ZERO_C = onewire_pkg::ZERO_HIGH_US / DIV;
	localparam int ONE_C  = onewire_pkg::ONE_HIGH_US / DIV;
	localparam int STOP_C = onewire_pkg::STOP_US / DIV;
	always #2.5 clk_i = ~clk_i;
	onewire_sensor_link #(.WAKE_MIN_CYC(WAKE_C), .ACK_LOW_CYC(ACK_C), .ACK_HIGH_CYC(ACK_C), .BIT_LOW_CYC(LOW_C),
		.ZERO_HIGH_CYC(ZERO_C), .ONE_HIGH_CYC(ONE_C), .STOP_CYC(STOP_C)) dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .data_line_i(~(oe | pull)), .data_line_o(drv),
		.data_line_oe_o(oe), .humidity_tenths_i(hum), .temp_negative_i(neg),
		.temp_magnitude_tenths_i(mag), .busy_o(busy), .sample_taken_o(taken));
	host_model #(.ACK_C(ACK_C), .LOW_C(LOW_C), .ZERO_C(ZERO_C), .ONE_C(ONE_C), .STOP_C(STOP_C)) host (
		.clk_i(clk_i), .oe_i(oe), .pull_o(pull));
	// whenever the pin pulls the wire it must drive low and report busy
	always @(posedge clk_i) begin
		if (taken === 1'b1) begin
			n_taken <= n_taken + 1;
		end
		if (oe === 1'b1 && (drv !== 1'b0 || busy !== 1'b1)) begin
			n_bad_pull <= n_bad_pull + 1;
		end
	end
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic t_frame(input logic [15:0] h, input logic s, input logic [14:0] m);
		logic [39:0] f;
		int          bad;
		logic        ok;
		logic [7:0]  sum;
		int          taken0;
		sum = h[15:8] + h[7:0] + {s, m[14:8]} + m[7:0];
		taken0 = n_taken;
		@(posedge clk_i);
		hum <= h;
		neg <= s;
		mag <= m;
		host.xfer(120, f, bad, ok);
		check("frame", {h, s, m, sum}, f);
		check("timing faults", 40'h0, 40'(bad));
		check("checksum ok", 40'h1, 40'(ok));
		repeat (2) @(posedge clk_i);
		check("busy after stop", 40'h0, 40'(busy));
		check("sample pulses", 40'(taken0 + 1), 40'(n_taken));
		check("pull faults", 40'h0, 40'(n_bad_pull));
	endtask
	// a wake shorter than the minimum must draw no answer at all
	task automatic t_short();
		logic [39:0] f;
		int          bad;
		logic        ok;
		int          taken0;
		taken0 = n_taken;
		host.xfer(20, f, bad, ok);
		check("short wake answer", 40'hff_ffff_ffff, 40'(bad));
		check("short wake pulses", 40'(taken0), 40'(n_taken));
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_frame(16'h0292, 1'b0, 15'h010d);
		t_frame(16'h0292, 1'b1, 15'h0065);
		t_frame(16'hffff, 1'b1, 15'h7fff);
		t_short();
		t_frame(16'h0000, 1'b0, 15'h0000);
		wrap_up();
	end
	// four readings and one refused wake take about 4000 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		wrap_up();
	end
endmodule
`default_nettype wire

// *** verilog/onewire_pkg.sv ***
`default_nettype none
package onewire_pkg;
	localparam int CLK_MHZ      = 200;
	localparam int WAKE_MIN_US  = 500;
	localparam int ACK_LOW_US   = 80;
	localparam int ACK_HIGH_US  = 80;
	localparam int BIT_LOW_US   = 50;
	localparam int ZERO_HIGH_US = 26;
	localparam int ONE_HIGH_US  = 70;
	localparam int STOP_US      = 45;
	localparam int CNT_W        = 24;
	localparam int BYTE_W       = 8;
	localparam int WORD_W       = 16;
	localparam int MAG_W        = 15;
	localparam int FRAME_BITS   = 40;
	localparam int IDX_W        = 6;
	localparam int FRAME_MSB    = FRAME_BITS - 1;
	localparam logic [IDX_W-1:0] LAST_BIT_IDX = 6'h27;
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_WAKE     = 3'h1,
		ST_ACK_LOW  = 3'h2,
		ST_ACK_HIGH = 3'h3,
		ST_BIT_LOW  = 3'h4,
		ST_BIT_HIGH = 3'h5,
		ST_STOP     = 3'h6
	} link_state_type;
endpackage
`default_nettype wire

// *** verilog/onewire_sensor_link.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - module acknowledges with 80 us low then 80 us high, each 75 to 85 us.
// - module then sends 40 bits: humidity, temperature, checksum, each MSB first.
// - every bit opens with a 50 us low phase, same for zero and one.
// - zero bit has a 26 us high phase after the low phase.
// - one bit has a 70 us high phase after the low phase.
// - after the last bit the module holds the line low at least 45 us, then releases.
// - humidity word carries ten times relative humidity, tenth percent resolution.
// - temperature word carries ten times temperature in degrees Celsius.
// - temperature bit 15 set means negative, clear means positive.
// - checksum byte is low eight bits of sum of the four data bytes.
module onewire_sensor_link #(
	parameter int WAKE_MIN_CYC  = onewire_pkg::WAKE_MIN_US * onewire_pkg::CLK_MHZ,
	parameter int ACK_LOW_CYC   = onewire_pkg::ACK_LOW_US * onewire_pkg::CLK_MHZ,
	parameter int ACK_HIGH_CYC  = onewire_pkg::ACK_HIGH_US * onewire_pkg::CLK_MHZ,
	parameter int BIT_LOW_CYC   = onewire_pkg::BIT_LOW_US * onewire_pkg::CLK_MHZ,
	parameter int ZERO_HIGH_CYC = onewire_pkg::ZERO_HIGH_US * onewire_pkg::CLK_MHZ,
	parameter int ONE_HIGH_CYC  = onewire_pkg::ONE_HIGH_US * onewire_pkg::CLK_MHZ,
	parameter int STOP_CYC      = onewire_pkg::STOP_US * onewire_pkg::CLK_MHZ
) (
	input  wire logic                            clk_i,
	input  wire logic                            reset_n_i,
	input  wire logic                            data_line_i,
	output logic                                 data_line_o,
	output logic                                 data_line_oe_o,
	input  wire logic [onewire_pkg::WORD_W-1:0]  humidity_tenths_i,
	input  wire logic                            temp_negative_i,
	input  wire logic [onewire_pkg::MAG_W-1:0]   temp_magnitude_tenths_i,
	output logic                                 busy_o,
	output logic                                 sample_taken_o
);
	import onewire_pkg::*;

	function automatic logic [CNT_W-1:0] last_cycle(input int cycles);
		last_cycle = CNT_W'(cycles - 1);
	endfunction

	logic                  line_meta_ff;
	logic                  line_sync_ff;
	link_state_type        state_ff;
	link_state_type        nxt_state;
	logic [CNT_W-1:0]      cnt_ff;
	logic [CNT_W-1:0]      nxt_cnt;
	logic [IDX_W-1:0]      bit_idx_ff;
	logic [FRAME_MSB:0]    frame_ff;
	logic                  oe_ff;
	logic                  taken_ff;
	logic                  phase_end;
	logic                  wake_long;
	logic                  take_sample;
	logic                  bit_done;
	logic [WORD_W-1:0]     temp_word;
	logic [BYTE_W-1:0]     chk_sum;

	// open drain: the line is only ever pulled low, high phases rely on the pull-up
	assign data_line_o    = 1'b0;
	assign data_line_oe_o = oe_ff;
	assign busy_o         = (state_ff != ST_IDLE) && (state_ff != ST_WAKE);
	assign sample_taken_o = taken_ff;

	assign temp_word = {temp_negative_i, temp_magnitude_tenths_i};
	assign chk_sum   = humidity_tenths_i[WORD_W-1:BYTE_W] + humidity_tenths_i[BYTE_W-1:0]
		+ temp_word[WORD_W-1:BYTE_W] + temp_word[BYTE_W-1:0];

	assign phase_end   = (cnt_ff == '0);
	assign wake_long   = (cnt_ff >= last_cycle(WAKE_MIN_CYC));
	assign take_sample = (state_ff == ST_WAKE) && line_sync_ff && wake_long;
	assign bit_done    = (state_ff == ST_BIT_HIGH) && phase_end;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			line_meta_ff <= 1'b1;
			line_sync_ff <= 1'b1;
		end else begin
			line_meta_ff <= data_line_i;
			line_sync_ff <= line_meta_ff;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = phase_end ? cnt_ff : cnt_ff - 1'b1;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_cnt = '0;
				if (!line_sync_ff) begin
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// counts the master's low time, saturating so a long hold never wraps
				nxt_cnt = wake_long ? cnt_ff : cnt_ff + 1'b1;
				if (line_sync_ff) begin
					// a short glitch is not a wake-up and is dropped
					nxt_state = wake_long ? ST_ACK_LOW : ST_IDLE;
					nxt_cnt   = last_cycle(ACK_LOW_CYC);
				end
			end
			ST_ACK_LOW: begin
				if (phase_end) begin
					nxt_state = ST_ACK_HIGH;
					nxt_cnt   = last_cycle(ACK_HIGH_CYC);
				end
			end
			ST_ACK_HIGH: begin
				if (phase_end) begin
					nxt_state = ST_BIT_LOW;
					nxt_cnt   = last_cycle(BIT_LOW_CYC);
				end
			end
			ST_BIT_LOW: begin
				if (phase_end) begin
					nxt_state = ST_BIT_HIGH;
					nxt_cnt   = frame_ff[FRAME_MSB] ? last_cycle(ONE_HIGH_CYC) : last_cycle(ZERO_HIGH_CYC);
				end
			end
			ST_BIT_HIGH: begin
				if (phase_end) begin
					if (bit_idx_ff == LAST_BIT_IDX) begin
						nxt_state = ST_STOP;
						nxt_cnt   = last_cycle(STOP_CYC);
					end else begin
						nxt_state = ST_BIT_LOW;
						nxt_cnt   = last_cycle(BIT_LOW_CYC);
					end
				end
			end
			ST_STOP: begin
				if (phase_end) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// the line is pulled low exactly in the acknowledge, bit and stop low phases
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= (nxt_state == ST_ACK_LOW) || (nxt_state == ST_BIT_LOW) || (nxt_state == ST_STOP);
		end
	end

	// the reading is frozen at the wake-up so all five bytes belong to one sample
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			frame_ff   <= '0;
			bit_idx_ff <= '0;
			taken_ff   <= 1'b0;
		end else begin
			taken_ff <= take_sample;
			if (take_sample) begin
				frame_ff   <= {humidity_tenths_i, temp_word, chk_sum};
				bit_idx_ff <= '0;
			end else if (bit_done) begin
				frame_ff   <= {frame_ff[FRAME_MSB-1:0], 1'b0};
				bit_idx_ff <= bit_idx_ff + 1'b1;
			end
		end
	end

	logic [CNT_W-1:0] phase_len_ff;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			phase_len_ff <= '0;
		end else begin
			phase_len_ff <= (nxt_state != state_ff) ? '0 : phase_len_ff + 1'b1;
		end
	end

	wire leaving = (nxt_state != state_ff);

	ack_low_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_ff == ST_ACK_LOW) && leaving |-> phase_len_ff == last_cycle(ACK_LOW_CYC))
		else $error("acknowledge low phase has wrong length");
	ack_high_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_ff == ST_ACK_HIGH) && leaving |-> phase_len_ff == last_cycle(ACK_HIGH_CYC) && !data_line_oe_o)
		else $error("acknowledge high phase has wrong length");
	bit_low_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_ff == ST_BIT_LOW) && leaving |-> phase_len_ff == last_cycle(BIT_LOW_CYC) && data_line_oe_o)
		else $error("bit low phase has wrong length");
	zero_high_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_ff == ST_BIT_HIGH) && leaving && !frame_ff[FRAME_MSB] |-> phase_len_ff == last_cycle(ZERO_HIGH_CYC))
		else $error("zero bit high phase has wrong length");
	one_high_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_ff == ST_BIT_HIGH) && leaving && frame_ff[FRAME_MSB] |-> phase_len_ff == last_cycle(ONE_HIGH_CYC))
		else $error("one bit high phase has wrong length");
	stop_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_ff == ST_STOP) && leaving |-> phase_len_ff >= last_cycle(STOP_CYC) ##1 !data_line_oe_o)
		else $error("stop marker too short or line not released");
	bit_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(nxt_state == ST_STOP) && leaving |-> bit_idx_ff == LAST_BIT_IDX)
		else $error("stop sent after wrong number of bits");
	frame_layout_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		take_sample |=> frame_ff[FRAME_MSB -: WORD_W] == $past(humidity_tenths_i)
			&& frame_ff[WORD_W+BYTE_W-1:BYTE_W] == $past(temp_word))
		else $error("frame words not loaded from the sample");
	sign_bit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		take_sample |=> frame_ff[WORD_W+BYTE_W-1] == $past(temp_negative_i)
			&& frame_ff[MAG_W+BYTE_W-1:BYTE_W] == $past(temp_magnitude_tenths_i))
		else $error("temperature sign or magnitude misplaced");
	checksum_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		take_sample |=> frame_ff[BYTE_W-1:0] == BYTE_W'(frame_ff[FRAME_MSB -: BYTE_W]
			+ frame_ff[FRAME_MSB-BYTE_W -: BYTE_W] + frame_ff[WORD_W+BYTE_W-1 -: BYTE_W]
			+ frame_ff[WORD_W-1 -: BYTE_W]))
		else $error("checksum byte does not match data bytes");
endmodule
`default_nettype wire
